// *** logic/rps_blink_gen.sv ***
`timescale 1ns/100ps
module rps_blink_gen
	import rps_pkg::*;
#(
	parameter logic [rps_pkg::TW-1:0] HALF_CYC = rps_pkg::TW'(rps_pkg::BLINK_CYC),
	parameter logic [rps_pkg::TW-1:0] SEC_CYC  = rps_pkg::TW'(rps_pkg::CLK_HZ)
) (
	input  wire logic hclk,    // System clock
	input  wire logic hresetn, // Async reset, low
	rps_time_if.gen   tif      // Shared timing
);
	logic [TW-1:0] half_cnt;
	logic [TW-1:0] sec_cnt;

	// One phase for every pattern keeps alternating LEDs complementary
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			half_cnt <= '0;
			tif.blink <= 1'b0;
		end else if (half_cnt >= HALF_CYC - TW'(1)) begin
			half_cnt <= '0;
			tif.blink <= ~tif.blink;
		end else begin
			half_cnt <= half_cnt + TW'(1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sec_cnt <= '0;
			tif.sec_tick <= 1'b0;
		end else begin
			tif.sec_tick <= (sec_cnt >= SEC_CYC - TW'(1));
			sec_cnt <= (sec_cnt >= SEC_CYC - TW'(1)) ? '0 : sec_cnt + TW'(1);
		end
	end
endmodule // rps_blink_gen

// *** logic/rps_idle_timer.sv ***
`timescale 1ns/100ps
module rps_idle_timer
	import rps_pkg::*;
#(
	parameter logic [rps_pkg::TW-1:0] IDLE_CYC = rps_pkg::TW'(rps_pkg::SAVE_CYC)
) (
	input  wire logic hclk,    // System clock
	input  wire logic hresetn, // Async reset, low
	rps_time_if.idle  tif      // Key activity in, sleep out
);
	logic [TW-1:0] idle_cnt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_cnt <= '0;
			tif.asleep <= 1'b0;
		end else if (tif.key_any) begin
			idle_cnt <= '0;
			tif.asleep <= 1'b0;
		end else if (idle_cnt >= IDLE_CYC - TW'(1)) begin
			tif.asleep <= 1'b1;
		end else begin
			idle_cnt <= idle_cnt + TW'(1);
		end
	end
endmodule // rps_idle_timer

// *** logic/rps_panel.sv ***
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
module rps_panel
	import rps_pkg::*;
#(
	parameter logic [rps_pkg::TW-1:0] IDLE_CYC = rps_pkg::TW'(rps_pkg::SAVE_CYC),
	parameter logic [rps_pkg::TW-1:0] HALF_CYC = rps_pkg::TW'(rps_pkg::BLINK_CYC),
	parameter logic [rps_pkg::TW-1:0] SEC_CYC  = rps_pkg::TW'(rps_pkg::CLK_HZ)
) (
	input  wire logic                    hclk,             // System clock
	input  wire logic                    hresetn,          // Async reset, low
	input  wire logic                    hsel,             // AHB select
	input  wire logic [7:0]              haddr,            // AHB address
	input  wire logic [1:0]              htrans,           // AHB transfer type
	input  wire logic                    hwrite,           // AHB write
	input  wire logic [2:0]              hsize,            // AHB size, word only
	input  wire logic [31:0]             hwdata,           // AHB write data
	input  wire logic                    hready,           // AHB bus ready
	output logic                         hreadyout,        // AHB slave ready
	output logic                         hresp,            // AHB response
	output logic [31:0]                  hrdata,           // AHB read data
	input  wire logic [rps_pkg::NKEY-1:0] keys,            // Panel key levels
	input  wire logic                    local_inhibit,    // Local inhibit request
	input  wire logic                    rem_valid,        // Supervisory command strobe
	input  wire logic [2:0]              rem_code,         // Supervisory command
	input  wire logic                    oc_trip,          // Protection trip issued
	input  wire logic                    above_pickup,     // Current above pickup
	input  wire logic                    seq_lockout,      // Sequence reached lockout
	input  wire logic                    seq_active,       // Reclosing in progress
	input  wire logic                    pos_open,         // Position open
	input  wire logic                    pos_closed,       // Position closed
	input  wire logic                    fail_trip,        // Failed to trip
	input  wire logic                    fail_close,       // Failed to close
	input  wire logic                    intr_fault,       // Interrupter fault event
	input  wire logic                    aux_disagree,     // breaker_aux_contacts disagree
	input  wire logic                    mains_sense,      // AC input sensed
	input  wire logic                    batt_low,         // Battery voltage low
	input  wire logic                    batt_test_fail,   // Last battery test failed
	input  wire logic                    batt_disc,        // Battery disconnected
	input  wire logic                    batt_trouble,     // Battery trouble
	input  wire logic                    clock_not_set,    // Clock not set
	input  wire logic                    ctrl_circ_open,   // Control circuit interrupted
	input  wire logic                    selftest_pass,    // Self-diagnostics passed
	input  wire logic                    settings_valid,   // User settings valid
	input  wire logic                    control_power,    // Control power present
	output logic                         led_oc_trip,      // Overcurrent trip LED
	output logic                         led_pickup,       // Pickup exceeded LED
	output logic                         led_lockout,      // Lockout LED
	output logic                         led_open,         // Open LED
	output logic                         led_closed,       // Closed LED
	output logic                         led_alarm,        // Alarm LED
	output logic                         led_health,       // Health LED
	output logic                         mains_present_indicator, // Mains LED
	output logic                         led_battery,      // Battery LED
	output logic                         led_inhibit,      // Inhibit key LED
	output logic                         led_block,        // Remote block key LED
	output logic                         led_single,       // Single-shot key LED
	output logic                         led_profile,      // Second set key LED
	output logic                         backlight,        // Display backlight
	output logic                         msg_prot_off,     // Protection-off message
	output logic [5:0]                   countdown,        // Seconds to close
	output logic                         trip_cmd,         // Trip pulse to mechanism
	output logic                         close_cmd,        // Close pulse to mechanism
	output logic                         seq_home,         // Reset sequence pulse
	output logic                         inrush_pickup_mode, // Inrush protection on
	output logic                         one_trip_lockout, // Inhibit protection mode
	output logic                         reclose_enable,   // Automatic reclose allowed
	output logic                         protection_enable,// Protection allowed
	output logic                         second_settings_set, // Second set active
	output logic                         batt_test_start   // Battery test pulse
);
	rps_time_if tif ();

	rps_blink_gen #(.HALF_CYC(HALF_CYC), .SEC_CYC(SEC_CYC)) u_blink (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tif     (tif.gen)
	);
	rps_idle_timer #(.IDLE_CYC(IDLE_CYC)) u_idle (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tif     (tif.idle)
	);

	logic [NKEY-1:0] keys_q;
	logic [NKEY-1:0] press;
	logic            ap_valid;
	logic            ap_write;
	logic [7:0]      ap_addr;
	logic [NALM-1:0] alm_en;
	logic [NALM-1:0] alm_ack;
	logic [NALM-1:0] alm_act;
	logic [31:0]     cfg;
	logic [31:0]     cmd_wr;
	logic            intr_latched;
	logic            oc_latched;
	logic            lockout;
	logic            inh_panel;
	logic            inh_remote;
	logic            inhibit;
	logic            rem_block;
	logic            single_shot;
	logic            booted;
	logic            diag;
	logic            alarm_on;
	logic            alarm_unack;
	logic [7:0]      open_secs;
	logic            rem_ok;
	logic            req_close;
	logic            req_trip;
	logic            close_now;
	logic [31:0]     status;
	logic [31:0]     next_rdata;
	rps_close_t      cl_state;

	assign press = keys & ~keys_q;
	assign tif.key_any = |press;
	assign rem_ok = rem_valid & ~rem_block;
	assign cmd_wr = (ap_valid && ap_write && ap_addr == ADDR_CMD) ? hwdata : 32'h0;
	assign inhibit = inh_panel | local_inhibit | inh_remote;
	assign diag = fail_trip | fail_close | intr_latched | aux_disagree;
	assign req_trip = (press[K_TRIP] | cmd_wr[C_TRIP] | (rem_ok && rem_code == R_TRIP)) & control_power;
	assign req_close = press[K_CLOSE] | cmd_wr[C_CLOSE] | (rem_ok && rem_code == R_CLOSE);
	// Second press while waiting overrides the delay
	assign close_now = req_close && !inhibit && !req_trip
		&& (cl_state == CL_WAIT || cfg[CFG_DLY_LSB +: CFG_DLY_W] == '0);

	assign alm_act[A_MAINS]  = mains_sense;
	assign alm_act[A_BDISC]  = batt_disc;
	assign alm_act[A_BFAIL]  = batt_test_fail;
	assign alm_act[A_BTRBL]  = batt_trouble;
	assign alm_act[A_CLOCK]  = clock_not_set;
	assign alm_act[A_CCIRC]  = ctrl_circ_open;
	assign alm_act[A_INTR]   = intr_latched;
	assign alm_act[A_FTRIP]  = fail_trip;
	assign alm_act[A_FCLOSE] = fail_close;
	assign alm_act[A_INDET]  = pos_open & pos_closed;
	assign alarm_on = |(alm_act & alm_en);
	assign alarm_unack = |(alm_act & alm_en & ~alm_ack);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			keys_q <= '0;
		else
			keys_q <= keys;
	end

	// Bus: zero wait state, read data registered at the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid <= 1'b0;
			ap_write <= 1'b0;
			ap_addr <= '0;
			hrdata <= '0;
		end else begin
			ap_valid <= hsel & hready & htrans[1];
			ap_write <= hwrite;
			ap_addr <= haddr;
			if (hsel && hready && htrans[1] && !hwrite)
				hrdata <= next_rdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	always_comb begin
		status = '0;
		status[ST_CNT_LSB +: 6] = countdown;
		status[13:0] = {inhibit, rem_block, single_shot, second_settings_set, lockout, cl_state == CL_WAIT,
			diag, alarm_on, alarm_unack, intr_latched, oc_latched, inrush_pickup_mode, tif.asleep, msg_prot_off};
		case (haddr)
			ADDR_STATUS:  next_rdata = status;
			ADDR_ALM_EN:  next_rdata = {22'h0, alm_en};
			ADDR_ALM_ACK: next_rdata = {22'h0, alm_ack};
			ADDR_CFG:     next_rdata = cfg;
			ADDR_ALM_ACT: next_rdata = {22'h0, alm_act};
			default:      next_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alm_en <= ALM_EN_RST;
			cfg <= CFG_RST;
		end else if (ap_valid && ap_write) begin
			if (ap_addr == ADDR_ALM_EN)
				alm_en <= hwdata[NALM-1:0];
			if (ap_addr == ADDR_CFG)
				cfg <= hwdata;
		end
	end

	// Ack drops when its alarm clears, so a recurrence flashes again
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			alm_ack <= '0;
		else if (ap_valid && ap_write && ap_addr == ADDR_ALM_ACK)
			alm_ack <= (alm_ack | hwdata[NALM-1:0]) & alm_act;
		else
			alm_ack <= alm_ack & alm_act;
	end

	// Set wins over reset targets
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			intr_latched <= 1'b0;
			oc_latched <= 1'b0;
		end else begin
			intr_latched <= intr_fault | (intr_latched & ~cmd_wr[C_RST_TGT]);
			oc_latched <= (oc_trip & above_pickup) | (oc_latched & ~cmd_wr[C_RST_TGT]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			inh_panel <= 1'b0;
			inh_remote <= 1'b0;
		end else begin
			if (press[K_INHIB])
				inh_panel <= ~inh_panel;
			if (rem_ok && rem_code == R_HLT_ON)
				inh_remote <= 1'b1;
			else if (rem_ok && rem_code == R_HLT_OFF)
				inh_remote <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rem_block <= 1'b0;
			single_shot <= 1'b0;
			second_settings_set <= 1'b0;
		end else begin
			if (press[K_BLOCK])
				rem_block <= ~rem_block;
			if (press[K_SINGLE])
				single_shot <= ~single_shot;
			else if (cmd_wr[C_SS_ON] || (rem_ok && rem_code == R_SS_ON))
				single_shot <= 1'b1;
			else if (cmd_wr[C_SS_OFF] || (rem_ok && rem_code == R_SS_OFF))
				single_shot <= 1'b0;
			if (press[K_PROF])
				second_settings_set <= ~second_settings_set;
			else if (cmd_wr[C_PR_ON] || (rem_ok && rem_code == R_PR_ON))
				second_settings_set <= 1'b1;
			else if (cmd_wr[C_PR_OFF] || (rem_ok && rem_code == R_PR_OFF))
				second_settings_set <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			open_secs <= '0;
		else if (!pos_open)
			open_secs <= '0;
		else if (tif.sec_tick && open_secs != 8'hff)
			open_secs <= open_secs + 8'h01;
	end

	// Close delay sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cl_state <= CL_IDLE;
			countdown <= '0;
		end else begin
			case (cl_state)
				CL_IDLE: begin
					if (req_close && !inhibit && !req_trip && !close_now) begin
						cl_state <= CL_WAIT;
						countdown <= cfg[CFG_DLY_LSB +: CFG_DLY_W];
					end
				end
				CL_WAIT: begin
					if (req_trip || inhibit || close_now) begin
						cl_state <= CL_IDLE;
						countdown <= '0;
					end else if (countdown == 6'h00) begin
						// Leave at expiry so the close fires once and the count never wraps
						cl_state <= CL_IDLE;
					end else if (tif.sec_tick) begin
						countdown <= countdown - 6'h01;
					end
				end
				default: begin
					cl_state <= CL_IDLE;
					countdown <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trip_cmd <= 1'b0;
			close_cmd <= 1'b0;
			seq_home <= 1'b0;
			lockout <= 1'b0;
			inrush_pickup_mode <= 1'b0;
		end else begin
			// Expiry of the countdown counts as a close now
			trip_cmd <= req_trip;
			close_cmd <= close_now || (cl_state == CL_WAIT && countdown == 6'h00 && !inhibit && !req_trip);
			seq_home <= close_now || (cl_state == CL_WAIT && countdown == 6'h00 && !inhibit && !req_trip);
			if (req_trip || seq_lockout)
				lockout <= 1'b1;
			else if (close_cmd)
				lockout <= 1'b0;
			if (req_trip || inhibit)
				inrush_pickup_mode <= 1'b0;
			else if (close_cmd && lockout && cfg[CFG_INRUSH] && open_secs > cfg[CFG_MIN_LSB +: CFG_MIN_W])
				inrush_pickup_mode <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			one_trip_lockout <= 1'b0;
			reclose_enable <= 1'b0;
			protection_enable <= 1'b0;
			batt_test_start <= 1'b0;
		end else begin
			one_trip_lockout <= inhibit;
			reclose_enable <= ~single_shot & ~inhibit & settings_valid;
			protection_enable <= settings_valid;
			batt_test_start <= press[K_BATT];
		end
	end

	// Settings are sampled after release, never under reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			booted <= 1'b0;
			msg_prot_off <= 1'b0;
		end else begin
			booted <= 1'b1;
			if (!booted)
				msg_prot_off <= ~settings_valid;
			else if (press[K_ESC] || tif.asleep)
				msg_prot_off <= 1'b0;
		end
	end

	// Health and inhibit stay live through power save
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			led_health <= 1'b0;
			led_inhibit <= 1'b0;
			backlight <= 1'b0;
		end else begin
			led_health <= selftest_pass & (settings_valid | tif.blink);
			led_inhibit <= inhibit;
			backlight <= ~tif.asleep;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			led_oc_trip <= 1'b0;
			led_pickup <= 1'b0;
			led_lockout <= 1'b0;
			led_open <= 1'b0;
			led_closed <= 1'b0;
			led_alarm <= 1'b0;
			mains_present_indicator <= 1'b0;
			led_battery <= 1'b0;
			led_block <= 1'b0;
			led_single <= 1'b0;
			led_profile <= 1'b0;
		end else if (tif.asleep) begin
			led_oc_trip <= 1'b0;
			led_pickup <= 1'b0;
			led_lockout <= 1'b0;
			led_open <= 1'b0;
			led_closed <= 1'b0;
			led_alarm <= 1'b0;
			mains_present_indicator <= 1'b0;
			led_battery <= 1'b0;
			led_block <= 1'b0;
			led_single <= 1'b0;
			led_profile <= 1'b0;
		end else begin
			led_oc_trip <= oc_latched;
			led_pickup <= above_pickup;
			if (diag) begin
				led_lockout <= tif.blink;
				led_closed <= tif.blink;
				led_open <= ~tif.blink;
			end else begin
				led_lockout <= lockout & ~seq_active;
				led_open <= pos_open;
				led_closed <= (cl_state == CL_WAIT) ? tif.blink : pos_closed;
			end
			led_alarm <= alarm_on & (~alarm_unack | tif.blink);
			mains_present_indicator <= mains_sense;
			led_battery <= batt_low | batt_test_fail;
			led_block <= rem_block;
			led_single <= single_shot;
			led_profile <= second_settings_set;
		end
	end
endmodule // rps_panel

// *** pkg/rps_pkg.sv ***
package rps_pkg;
	localparam logic [7:0] ADDR_STATUS  = 8'h00;
	localparam logic [7:0] ADDR_ALM_EN  = 8'h04;
	localparam logic [7:0] ADDR_ALM_ACK = 8'h08;
	localparam logic [7:0] ADDR_CMD     = 8'h0c;
	localparam logic [7:0] ADDR_CFG     = 8'h10;
	localparam logic [7:0] ADDR_ALM_ACT = 8'h14;
	localparam int NALM = 10;
	localparam logic [NALM-1:0] ALM_EN_RST = 10'h3ff;
	localparam int A_MAINS = 0, A_BDISC = 1, A_BFAIL = 2, A_BTRBL = 3, A_CLOCK = 4;
	localparam int A_CCIRC = 5, A_INTR = 6, A_FTRIP = 7, A_FCLOSE = 8, A_INDET = 9;
	localparam int NKEY = 9;
	localparam int K_TRIP = 0, K_CLOSE = 1, K_INHIB = 2, K_BLOCK = 3, K_SINGLE = 4;
	localparam int K_BATT = 5, K_PROF = 6, K_ESC = 7, K_NAV = 8;
	localparam int C_RST_TGT = 0, C_CLOSE = 1, C_TRIP = 2, C_SS_ON = 3, C_SS_OFF = 4;
	localparam int C_PR_ON = 5, C_PR_OFF = 6;
	localparam int CFG_DLY_LSB = 0, CFG_DLY_W = 6, CFG_MIN_LSB = 8, CFG_MIN_W = 8;
	localparam int CFG_INRUSH = 16;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam int ST_CNT_LSB = 16;
	localparam logic [2:0] R_TRIP = 3'h0, R_CLOSE = 3'h1, R_HLT_ON = 3'h2, R_HLT_OFF = 3'h3;
	localparam logic [2:0] R_SS_ON = 3'h4, R_SS_OFF = 3'h5, R_PR_ON = 3'h6, R_PR_OFF = 3'h7;
	localparam longint CLK_HZ = 200_000_000;
	localparam longint SAVE_MIN = 15;
	localparam longint SAVE_CYC = SAVE_MIN * 60 * CLK_HZ;
	localparam longint BLINK_MS = 500;
	localparam longint BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
	localparam int TW = 40;
	typedef enum logic [1:0] {CL_IDLE = 2'b01, CL_WAIT = 2'b10} rps_close_t;
endpackage

// *** pkg/rps_time_if.sv ***
`timescale 1ns/100ps
interface rps_time_if;
	logic blink;
	logic sec_tick;
	logic key_any;
	logic asleep;
	modport gen (output blink, output sec_tick);
	modport idle (input key_any, output asleep);
	modport core (input blink, input sec_tick, input asleep, output key_any);
endinterface // rps_time_if

// *** verification/rps_asserts.sv ***
`timescale 1ns/100ps
module rps_asserts
	import rps_pkg::*;
(
	input wire logic                     hclk,          // Clock
	input wire logic                     hresetn,       // Reset
	input wire logic [rps_pkg::NKEY-1:0] keys,          // Keys
	input wire logic                     control_power, // Power
	input wire logic                     above_pickup,  // Pickup
	input wire logic                     mains_sense,   // AC in
	input wire logic                     selftest_pass, // Self-test
	input wire logic                     settings_valid,// Settings
	input wire logic                     fail_trip,     // Diag
	input wire logic                     backlight,     // Awake
	input wire logic                     led_pickup,    // LED
	input wire logic                     mains_present_indicator, // LED
	input wire logic                     led_health,    // LED
	input wire logic                     led_open,      // LED
	input wire logic                     led_closed,    // LED
	input wire logic                     led_lockout,   // LED
	input wire logic                     led_inhibit,   // LED
	input wire logic                     trip_cmd,      // Pulse
	input wire logic                     close_cmd      // Pulse
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	pickup_follow_a: assert property (backlight && $past(backlight) |-> led_pickup == $past(above_pickup))
		else $error("pickup led wrong");
	mains_follow_a: assert property (backlight && $past(backlight) |-> mains_present_indicator == $past(mains_sense))
		else $error("mains led wrong");
	health_on_a: assert property ($past(hresetn, 2) && $past(selftest_pass) && $past(settings_valid) |-> led_health)
		else $error("health led not steady");
	trip_key_a: assert property ($rose(keys[K_TRIP]) && control_power |-> ##[1:2] trip_cmd)
		else $error("trip key gave no trip");
	trip_pulse_a: assert property (trip_cmd |=> !trip_cmd)
		else $error("trip pulse too long");
	close_pulse_a: assert property (close_cmd |=> !close_cmd)
		else $error("close pulse too long");
	sleep_blank_a: assert property (!backlight && $past(!backlight) |-> !(led_pickup || led_open || led_closed))
		else $error("led lit while asleep");
	inhibit_close_a: assert property (led_inhibit && $past(led_inhibit) |-> !close_cmd)
		else $error("close while inhibited");
	diag_blink_a: assert property (fail_trip && $past(fail_trip) && $past(fail_trip, 2) && backlight && $past(backlight)
		|-> led_lockout == led_closed && led_open != led_closed)
		else $error("diag blink wrong");
endmodule // rps_asserts
bind rps_panel rps_asserts u_rps_asserts (.*);

// *** verification/rps_mech.sv ***
`timescale 1ns/100ps
module rps_mech (
	input  wire logic hclk,      // Clock
	input  wire logic slow,      // Slow travel
	input  wire logic trip_cmd,  // Open pulse
	input  wire logic close_cmd, // Close pulse
	output logic      pos_open,  // Open contact
	output logic      pos_closed // Closed contact
);
	int   cnt = 0;
	logic tgt = 1'b1;
	initial {pos_open, pos_closed} = 2'b10;
	// Both contacts drop during travel, as a real mechanism does
	always @(posedge hclk) begin
		if (trip_cmd || close_cmd) begin
			tgt <= trip_cmd;
			cnt <= slow ? 20 : 2;
			{pos_open, pos_closed} <= 2'b00;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end else if (cnt == 1) begin
			cnt <= 0;
			{pos_open, pos_closed} <= {tgt, !tgt};
		end
	end
endmodule // rps_mech

// *** verification/rps_panel_tb_top.sv ***
`timescale 1ns/100ps
module rps_panel_tb_top;
	import rps_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, slow = 0, rem_valid = 0, rd_ph = 0, hready;
	logic [7:0] haddr = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2, rem_code = 0;
	logic [31:0] hwdata = 0, hrdata, d;
	logic [NKEY-1:0] keys = 0;
	logic [63:0] q[$];
	logic oc_trip = 0, above_pickup = 0, seq_lockout = 0, seq_active = 0, fail_trip = 0, fail_close = 0;
	logic intr_fault = 0, aux_disagree = 0, mains_sense = 0, batt_low = 0, batt_test_fail = 0, batt_disc = 0;
	logic batt_trouble = 0, clock_not_set = 0, ctrl_circ_open = 0, local_inhibit = 0;
	logic selftest_pass = 1, settings_valid = 1, control_power = 1;
	logic hreadyout, hresp, pos_open, pos_closed, led_oc_trip, led_pickup, led_lockout, led_open, led_closed;
	logic led_alarm, led_health, mains_present_indicator, led_battery, led_inhibit, led_block, led_single;
	logic led_profile, backlight, msg_prot_off, trip_cmd, close_cmd, seq_home, inrush_pickup_mode;
	logic one_trip_lockout, reclose_enable, protection_enable, second_settings_set, batt_test_start;
	logic [5:0] countdown;
	int fail_count = 0, samples_checked = 0, seed = 43, i;
	assign hready = hreadyout;
	rps_panel #(.IDLE_CYC(40'd200), .HALF_CYC(40'd4), .SEC_CYC(40'd10)) u_rps_panel (.*);
	rps_mech u_rps_mech (.*);
	initial forever #2.5 hclk = ~hclk;
	task automatic stop_test;
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic wait_for(ref logic s);
		for (i = 0; i < 200 && s !== 1'b1; i++) @(posedge hclk);
		if (i == 200) begin
			fail_count++;
			stop_test();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dd, m);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		tick(1);
		wait_for(hreadyout);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= dd;
		if (!w) q.push_back({m, dd & m});
		rd_ph <= !w;
		tick(1);
		wait_for(hreadyout);
		rd_ph <= 0;
	endtask
	// Result side: oldest note is taken when read data is due
	always @(posedge hclk) begin
		logic [63:0] t;
		if (rd_ph && hreadyout) begin
			t = q.pop_front();
			check("rdata", hrdata & t[63:32], t[31:0]);
		end
	end
	task automatic press(input int k);
		keys[k] <= 1;
		tick(1);
		keys[k] <= 0;
		tick(2);
	endtask
	task automatic rem(input logic [2:0] c);
		rem_valid <= 1;
		rem_code <= c;
		tick(1);
		rem_valid <= 0;
		tick(2);
	endtask
	initial begin
		tick(8);
		hresetn <= 1;
		tick(2);
		bus(0, ADDR_ALM_EN, 32'h3ff, '1);
		bus(0, 8'h18, 32'h0, '1);
		repeat (8) begin
			{above_pickup, mains_sense, batt_low, batt_test_fail, batt_disc, batt_trouble, ctrl_circ_open,
				seq_active, seq_lockout, aux_disagree} <= 10'($random(seed));
			d = $random(seed);
			bus(1, ADDR_ALM_EN, d, 0);
			bus(0, ADDR_ALM_EN, d, 32'h3ff);
			check("batt", led_battery, batt_low | batt_test_fail);
		end
		{above_pickup, mains_sense, batt_low, batt_test_fail, batt_disc, batt_trouble, ctrl_circ_open,
			seq_active, seq_lockout, aux_disagree} <= 0;
		clock_not_set <= 1;
		bus(1, ADDR_ALM_EN, 32'h3ef, 0);
		bus(0, ADDR_STATUS, 0, 32'h40);
		bus(1, ADDR_ALM_EN, 32'h3ff, 0);
		bus(0, ADDR_STATUS, 32'h60, 32'h60);
		bus(1, ADDR_ALM_ACK, 32'h10, 0);
		bus(0, ADDR_STATUS, 32'h40, 32'h60);
		check("alarm", led_alarm, 1);
		clock_not_set <= 0;
		press(K_TRIP);
		wait_for(pos_open);
		tick(2);
		check("open", {led_open, led_closed, led_lockout}, 3'b101);
		bus(0, ADDR_STATUS, 32'h200, 32'h200);
		slow <= 1;
		bus(1, ADDR_CFG, 32'h10005, 0);
		press(K_CLOSE);
		check("count", countdown >= 6'h4, 1);
		bus(0, ADDR_STATUS, 32'h100, 32'h100);
		wait_for(pos_closed);
		tick(2);
		check("closed", {led_open, led_closed}, 2'b01);
		bus(0, ADDR_STATUS, 32'h4, 32'h304);
		oc_trip <= 1;
		intr_fault <= 1;
		above_pickup <= 1;
		tick(1);
		oc_trip <= 0;
		intr_fault <= 0;
		tick(2);
		check("oc", led_oc_trip, 1);
		bus(0, ADDR_STATUS, 32'h18, 32'h18);
		above_pickup <= 0;
		bus(1, ADDR_CMD, 32'h1, 0);
		bus(0, ADDR_STATUS, 0, 32'h18);
		local_inhibit <= 1;
		press(K_TRIP);
		press(K_INHIB);
		local_inhibit <= 0;
		press(K_CLOSE);
		tick(40);
		check("held", {pos_open, led_inhibit, one_trip_lockout}, 3'b111);
		press(K_INHIB);
		check("free", led_inhibit, 0);
		rem(3'h4);
		check("single", {led_single, reclose_enable}, 2'b10);
		press(K_BLOCK);
		rem(3'h6);
		check("blocked", second_settings_set, 0);
		bus(1, ADDR_CMD, 32'h20, 0);
		tick(2);
		check("profile", {led_profile, second_settings_set}, 2'b11);
		fail_trip <= 1;
		tick(20);
		fail_trip <= 0;
		tick(210);
		check("dark", {backlight, led_health, led_open}, 3'b010);
		press(K_NAV);
		check("wake", backlight, 1);
		// Second reset with bad settings: message at power-up, flashing health
		settings_valid <= 0;
		hresetn <= 0;
		tick(2);
		hresetn <= 1;
		tick(3);
		check("prot", {msg_prot_off, protection_enable}, 2'b10);
		press(K_ESC);
		d[0] = led_health;
		check("esc", msg_prot_off, 0);
		tick(4);
		check("flash", led_health, !d[0]);
		check("resp", {hresp, hreadyout}, 2'b01);
		stop_test();
	end
endmodule // rps_panel_tb_top
